// >>> pflm_pkg.sv
`default_nettype none

package pflm_pkg;

  // Clock rate in kHz, used to turn times into cycle counts
  localparam int unsigned CLK_KHZ = 125000;

  // Grace and settle interval, in microseconds
  localparam int unsigned HOLD_US = 2200;
  localparam int unsigned HOLD_CYCLES = (HOLD_US * (CLK_KHZ / 1000));

  // A 10 kHz pulse train edges every 50 us; allow twice the period
  localparam int unsigned PULSE_GAP_US = 200;
  localparam int unsigned PULSE_GAP_CYCLES =
    (PULSE_GAP_US * (CLK_KHZ / 1000));

  // Steady high this long counts as the end of the pulse train
  localparam int unsigned STEADY_US = 400;
  localparam int unsigned STEADY_CYCLES = (STEADY_US * (CLK_KHZ / 1000));

  // Edges inside one gap window needed to call it a failure train
  localparam logic [2:0] FAIL_EDGES = 3'h3;

  // Interrupt presentation
  localparam logic [2:0] IRQ_LEVEL     = 3'h4;
  localparam logic [7:0] TICK_DEVICE   = 8'h01;
  localparam logic [7:0] PFAIL_DEVICE  = 8'h00;
  localparam logic [7:0] PRESET_DEVICE = 8'h00;

  localparam int unsigned TIMER_W = 20;

  // Reset values
  localparam logic SYNC_RESET = 1'b1;

  typedef enum logic [3:0] {
    PFLM_NORMAL  = 4'b0001,
    PFLM_GRACE   = 4'b0010,
    PFLM_BLOCKED = 4'b0100,
    PFLM_SETTLE  = 4'b1000
  } pflm_state_type;

endpackage : pflm_pkg

`default_nettype wire

// >>> pflm_sync.sv
`default_nettype none

// Two-stage synchroniser for an input from outside this clock domain
module pflm_sync
  import pflm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_reg;
  logic sync_reg;

  // First stage feeds only the second; idle high matches a quiet line
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end
    else if (clk_en)
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : pflm_sync

`default_nettype wire

// >>> pflm_monitor.sv
`default_nettype none

// What this block does
// [RQ1] Supply holds power status steadily high while mains power is good.
// [RQ2] Supply sends a 10 kHz pulse train on power status on failure.
// [RQ3] Detect the pulse train and raise a level 4 power-fail interrupt.
// [RQ4] Time 2.2 ms after power-fail, then stop granting bus transactions.
// [RQ5] Processor must service power-fail within the 2.2 ms grace interval.
// [RQ6] On steady high, wait 2.2 ms then raise level 4 power-reset interrupt.
// [RQ7] Supply drives line frequency low 8.2 ms each mains cycle, about 60 Hz.
// [RQ8] Raise one level 4 interrupt for every line frequency pulse.
// [RQ9] Tick interrupt sits on level 4 and names device number 1; with a power interrupt in the same cycle the code names device 0.
// [RQ10] Processor traps when tick interrupts are missing or mistimed.
// [RQ11] Sync both lines; repeated edges mean failure, steady high recovery.
module pflm_monitor
  import pflm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       power_status_n,
  input  wire logic       line_freq_pulse_n,
  output var  logic       pfail_irq,
  output var  logic       preset_irq,
  output var  logic       tick_irq,
  output var  logic [2:0] irq_level,
  output var  logic [7:0] irq_device,
  output var  logic       bus_block
);

  logic                 pwr_sync;
  logic                 lf_sync;
  logic                 pwr_prev_reg;
  logic                 lf_prev_reg;
  logic [TIMER_W-1:0]   gap_reg;
  logic [TIMER_W-1:0]   gap_next;
  logic [2:0]           edges_reg;
  logic [2:0]           edges_next;
  logic [TIMER_W-1:0]   high_reg;
  logic [TIMER_W-1:0]   high_next;
  logic [TIMER_W-1:0]   hold_reg;
  logic [TIMER_W-1:0]   hold_next;
  pflm_state_type       state_reg;
  pflm_state_type       state_next;
  logic                 pfail_irq_reg;
  logic                 preset_irq_reg;
  logic                 tick_irq_reg;
  logic [2:0]           irq_level_reg;
  logic [7:0]           irq_device_reg;
  logic                 bus_block_reg;

  // Both lines come from the supply, so each gets a synchroniser
  pflm_sync u_pwr_sync (                                           // [RQ11]
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (power_status_n),
    .sync_out (pwr_sync)
  );

  pflm_sync u_lf_sync (                                            // [RQ11]
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (line_freq_pulse_n),
    .sync_out (lf_sync)
  );

  // Edge decode on the synchronised lines
  wire pwr_edge = (pwr_sync != pwr_prev_reg);
  wire lf_fall  = (!lf_sync) && lf_prev_reg;                       // [RQ8]

  // Edge counter restarts whenever the gap between edges is too long
  wire gap_open = (gap_reg < TIMER_W'(PULSE_GAP_CYCLES));
  assign gap_next = pwr_edge ? '0 :
                    (gap_open ? gap_reg + 1'b1 : gap_reg);
  assign edges_next = pwr_edge ?
                      (gap_open ? ((edges_reg == 3'h7) ? edges_reg :
                                   edges_reg + 3'h1) : 3'h1) :
                      (gap_open ? edges_reg : 3'h0);
  wire train_seen = (edges_reg >= FAIL_EDGES);                     // [RQ11]

  // Steady high detector; a single edge restarts it
  assign high_next = (pwr_edge || !pwr_sync) ? '0 :
                     ((high_reg < TIMER_W'(STEADY_CYCLES)) ?
                      high_reg + 1'b1 : high_reg);
  wire steady_high = (high_reg == TIMER_W'(STEADY_CYCLES));        // [RQ11]

  // Grace and settle both run the same 2.2 ms timer
  wire hold_done = (hold_reg == TIMER_W'(HOLD_CYCLES - 1));
  wire timing    = (state_reg == PFLM_GRACE) ||
                   (state_reg == PFLM_SETTLE);
  // Any change of state clears the timer, so a train that cuts settle
  // short still gets a full grace interval rather than the settle leftover
  wire hold_run  = timing && !hold_done && (state_next == state_reg);
  assign hold_next = hold_run ? hold_reg + 1'b1 : '0;             // [RQ4]

  // Sequencer; a new pulse train during settle starts a new failure
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PFLM_NORMAL:
        if (train_seen)
          state_next = PFLM_GRACE;                                 // [RQ3]
      PFLM_GRACE:
        if (hold_done)
          state_next = PFLM_BLOCKED;                               // [RQ4]
      PFLM_BLOCKED:
        if (steady_high)
          state_next = PFLM_SETTLE;                                // [RQ6]
      PFLM_SETTLE:
        if (train_seen)
          state_next = PFLM_GRACE;
        else if (hold_done)
          state_next = PFLM_NORMAL;                                // [RQ6]
      default:
        state_next = PFLM_NORMAL;
    endcase
  end

  // Interrupt pulses; a tick in the same cycle as a power event is
  // still raised, each on its own line, so none is lost
  wire pfail_fire  = (state_reg != PFLM_GRACE) &&
                     (state_next == PFLM_GRACE);                   // [RQ3]
  wire preset_fire = (state_reg == PFLM_SETTLE) &&
                     (state_next == PFLM_NORMAL);                  // [RQ6]
  wire tick_fire   = lf_fall;                                      // [RQ8]

  // Device identity on the shared level; power events take precedence
  wire [7:0] dev_sel = pfail_fire  ? PFAIL_DEVICE :
                       preset_fire ? PRESET_DEVICE :
                       TICK_DEVICE;                                // [RQ9]
  wire any_fire = pfail_fire || preset_fire || tick_fire;

  // Detector state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pwr_prev_reg <= 1'b1;
      lf_prev_reg  <= 1'b1;
      gap_reg      <= '0;
      edges_reg    <= 3'h0;
      high_reg     <= '0;
    end
    else if (clk_en)
    begin
      pwr_prev_reg <= pwr_sync;
      lf_prev_reg  <= lf_sync;
      gap_reg      <= gap_next;
      edges_reg    <= edges_next;
      high_reg     <= high_next;
    end
  end

  // Sequencer and timer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= PFLM_NORMAL;
      hold_reg  <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      hold_reg  <= hold_next;
    end
  end

  // Registered outputs; level and device hold the last presented event
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pfail_irq_reg  <= 1'b0;
      preset_irq_reg <= 1'b0;
      tick_irq_reg   <= 1'b0;
      irq_level_reg  <= IRQ_LEVEL;
      irq_device_reg <= TICK_DEVICE;
      bus_block_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      pfail_irq_reg  <= pfail_fire;
      preset_irq_reg <= preset_fire;
      tick_irq_reg   <= tick_fire;                                 // [RQ8]
      irq_level_reg  <= IRQ_LEVEL;                                 // [RQ9]
      if (any_fire)
        irq_device_reg <= dev_sel;
      bus_block_reg  <= (state_next == PFLM_BLOCKED);              // [RQ4]
    end
  end

  assign pfail_irq  = pfail_irq_reg;
  assign preset_irq = preset_irq_reg;
  assign tick_irq   = tick_irq_reg;
  assign irq_level  = irq_level_reg;
  assign irq_device = irq_device_reg;
  assign bus_block  = bus_block_reg;

  // Helper count of grace cycles between power-fail and the block
  logic [TIMER_W-1:0] grace_cnt_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      grace_cnt_reg <= '0;
    else if (clk_en)
      grace_cnt_reg <= pfail_fire ? '0 :
                       ((state_reg == PFLM_GRACE) ?
                        grace_cnt_reg + 1'b1 : grace_cnt_reg);
  end

  a_block_after_grace: assert property (                           // [RQ4]
    @(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(bus_block)) |->
      (grace_cnt_reg == TIMER_W'(HOLD_CYCLES)))
    else $error("bus block did not follow a full grace interval");

  a_grace_timer_clear: assert property (                           // [RQ4]
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(pfail_irq) |-> (hold_reg == '0))
    else $error("grace interval started with a stale timer count");

  a_pfail_has_train: assert property (                             // [RQ3]
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(pfail_irq) |-> (state_reg == PFLM_GRACE))
    else $error("power-fail interrupt without entering grace");

  a_no_block_grace: assert property (                              // [RQ4]
    @(posedge clk_sys) disable iff (!rst_b)
    (state_reg == PFLM_GRACE) |-> !bus_block)
    else $error("bus blocked during grace interval");

  a_reset_irq_unblocks: assert property (                          // [RQ6]
    @(posedge clk_sys) disable iff (!rst_b)
    preset_irq |-> (!bus_block && state_reg == PFLM_NORMAL))
    else $error("power-reset interrupt while bus still blocked");

  a_settle_full_hold: assert property (                            // [RQ6]
    @(posedge clk_sys) disable iff (!rst_b)
    (clk_en && state_reg == PFLM_SETTLE && state_next == PFLM_NORMAL)
      |-> (hold_reg == TIMER_W'(HOLD_CYCLES - 1)))
    else $error("power reset raised before settle interval ended");

  a_tick_per_pulse: assert property (                              // [RQ8]
    @(posedge clk_sys) disable iff (!rst_b)
    (clk_en && lf_sync == 1'b0 && lf_prev_reg == 1'b1) |=> tick_irq)
    else $error("line frequency pulse gave no tick interrupt");

  a_tick_single: assert property (                                 // [RQ8]
    @(posedge clk_sys) disable iff (!rst_b)
    (clk_en && tick_irq) |=> !tick_irq)
    else $error("tick interrupt longer than one cycle");

  a_tick_identity: assert property (                               // [RQ9]
    @(posedge clk_sys) disable iff (!rst_b)
    (tick_irq && !pfail_irq && !preset_irq) |->
      (irq_level == 3'h4 && irq_device == 8'h01))
    else $error("tick interrupt not on level 4 device 1");

  a_level_four: assert property (                                  // [RQ3]
    @(posedge clk_sys) disable iff (!rst_b)
    (pfail_irq || preset_irq) |-> (irq_level == 3'h4))
    else $error("power interrupt not on level 4");

endmodule : pflm_monitor

`default_nettype wire

// >>> pflm_supply.sv
`default_nettype none

// Behavioural power supply: power status line and mains-frequency line
module pflm_supply
(
  input  wire logic       clk_sys,
  input  wire logic       train_on,
  input  wire logic       freq_on,
  input  wire logic [4:0] lo_len,
  input  wire logic [4:0] hi_len,
  output var  logic       power_status_n,
  output var  logic       line_freq_pulse_n,
  output var  int         falls
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half period of the 10 kHz failure train at 125 MHz
  localparam int HALF = 6250;
  int tr_cnt;
  int fq_cnt;

  // Both lines idle high before the first edge
  initial
  begin
    power_status_n = 1'b1;
    line_freq_pulse_n = 1'b1;
    falls = 0;
    tr_cnt = 0;
    fq_cnt = 0;
  end

  // Train toggles only while power is failing; steady high otherwise
  always @(posedge clk_sys)
  begin
    if (!train_on)
    begin
      power_status_n <= 1'b1;
      tr_cnt <= 0;
    end
    else if (tr_cnt == 0)
    begin
      power_status_n <= ~power_status_n;
      tr_cnt <= HALF - 1;
    end
    else
      tr_cnt <= tr_cnt - 1;
  end

  // Mains pulse, shortened so a run holds many of them
  always @(posedge clk_sys)
  begin
    if (fq_cnt != 0)
      fq_cnt <= fq_cnt - 1;
    else if (line_freq_pulse_n && freq_on)
    begin
      line_freq_pulse_n <= 1'b0;
      falls <= falls + 1;
      fq_cnt <= int'(lo_len) - 1;
    end
    else if (!line_freq_pulse_n)
    begin
      line_freq_pulse_n <= 1'b1;
      fq_cnt <= int'(hi_len) - 1;
    end
  end
endmodule : pflm_supply

`default_nettype wire

// >>> power_fail_line_freq_monitor_test.sv
`default_nettype none

`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module power_fail_line_freq_monitor_test
  import pflm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys;
  logic       rst_b;
  logic       clk_en;
  logic       train_on;
  logic       freq_on;
  logic [4:0] lo_len;
  logic [4:0] hi_len;
  logic       power_status_n;
  logic       line_freq_pulse_n;
  logic       pfail_irq;
  logic       preset_irq;
  logic       tick_irq;
  logic [2:0] irq_level;
  logic [7:0] irq_device;
  logic       bus_block;
  logic       block_seen;
  int         falls;
  int         seed;
  int         failures;
  int         comparisons;
  int         ticks;
  int         pfails;
  int         presets;

  pflm_monitor pflm_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .power_status_n(power_status_n),
    .line_freq_pulse_n(line_freq_pulse_n), .pfail_irq(pfail_irq),
    .preset_irq(preset_irq), .tick_irq(tick_irq), .irq_level(irq_level),
    .irq_device(irq_device), .bus_block(bus_block));

  pflm_supply pflm_supply_i (.clk_sys(clk_sys), .train_on(train_on),
    .freq_on(freq_on), .lo_len(lo_len), .hi_len(hi_len),
    .power_status_n(power_status_n),
    .line_freq_pulse_n(line_freq_pulse_n), .falls(falls));

  always #4 clk_sys = ~clk_sys;

  // Verdict in one place, shared by the main sequence and the watchdog
  task give_verdict;
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Count interrupt pulses and check what each tick and power-fail pulse presents
  always @(posedge clk_sys)
  begin
    if (rst_b === 1'b1)
    begin
      if (bus_block === 1'b1)
        block_seen = 1'b1;
      if (preset_irq === 1'b1)
        presets++;
      if (tick_irq === 1'b1)
        ticks++;
      if (tick_irq === 1'b1 && pfail_irq !== 1'b1)
        `CHECK("tick device", TICK_DEVICE, irq_device)
      if (pfail_irq === 1'b1)
      begin
        pfails++;
        `CHECK("pfail device", PFAIL_DEVICE, irq_device)
      end
      if (tick_irq === 1'b1 || pfail_irq === 1'b1)
        `CHECK("irq level", IRQ_LEVEL, irq_level)
    end
  end

  // Main sequence: reset, random mains pulses, then a failure train
  initial
  begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    train_on = 1'b0;
    freq_on = 1'b0;
    lo_len = 5'h02;
    hi_len = 5'h02;
    block_seen = 1'b0;
    seed = 66;
    failures = 0;
    comparisons = 0;
    ticks = 0;
    pfails = 0;
    presets = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHECK("reset level", IRQ_LEVEL, irq_level)
    `CHECK("reset device", TICK_DEVICE, irq_device)
    `CHECK("reset block", 1'b0, bus_block)
    @(posedge clk_sys);
    freq_on <= 1'b1;
    // Widths down to two cycles give back-to-back edges
    repeat (30)
    begin
      lo_len <= 5'h02 + 5'($random(seed) & 15);
      hi_len <= 5'h02 + 5'($random(seed) & 15);
      repeat (40) @(posedge clk_sys);
    end
    // Failure train: third edge lands 12500 cycles in
    train_on <= 1'b1;
    repeat (12400) @(posedge clk_sys);
    `CHECK("pfail early", 0, pfails)
    repeat (120) @(posedge clk_sys);
    `CHECK("pfail raised", 1, pfails)
    repeat (18730) @(posedge clk_sys);
    train_on <= 1'b0;
    // Grace runs far longer than this, so no block and no reset yet
    repeat (40000) @(posedge clk_sys);
    freq_on <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHECK("tick count", falls, ticks)
    `CHECK("pfail count", 1, pfails)
    `CHECK("preset count", 0, presets)
    `CHECK("block early", 1'b0, block_seen)
    give_verdict;
  end

  // Watchdog: the sequence needs about 72500 cycles
  initial
  begin
    #800000;
    failures++;
    give_verdict;
  end
endmodule : power_fail_line_freq_monitor_test

`default_nettype wire
